// >>> rtl/sncr_node_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - switch clock divider, 16-bit read-write low field, resets to zero.
// - reference clock divider, 16-bit read-write low field, resets to three.
// - user code reads otp code in 31:18 and metal id in 17:0.
// - scan device identity reads as a fixed 32-bit word, four fields.
// - low direction table holds dimensions 7..0, four bits each, reset zero.
// - high direction table holds dimensions 15..8, four bits each, reset zero.
// - route uses direction of most significant bit where destination differs from node.
// - tile config bit 1 lets the shared debug net request debug of that core.
// - tile config bit 0 lets that core's halted flag drive the shared net.
// - debug source records last event origin: bit 4 pin, bits 1/0 cores.
// - link status bits 25:24 report the source kind, read-only.
// - link status bits 23:16 report the destination link while in use.
// - external link bits 11:8 hold its direction, read-write, reset zero.
// - link status bits 5:4 hold its network number, read-write, reset zero.
// - bit 2 shows the current packet is junk being discarded.
// - bit 1 shows destination side busy, bit 0 source side busy.
// - processor link status at 0x40..0x47, same fields but no direction.
// - node identifier, 16-bit read-write, reset zero, compared for routing.
module sncr_node_regs #(
  parameter int EXT_LINKS = sncr_pkg::EXT_LINKS,
  parameter int PROC_LINKS = sncr_pkg::PROC_LINKS,
  parameter logic [31:0] SCAN_ID = 32'h1234_5679, // arbitrary value
  parameter logic [13:0] OTP_USER_CODE = 14'h0000, // arbitrary value
  parameter logic [17:0] METAL_ID = 18'h00001 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire sncr_pkg::sncr_cfg_req_type cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire sncr_pkg::sncr_link_stat_type [EXT_LINKS-1:0] ext_stat,
  input wire sncr_pkg::sncr_link_stat_type [PROC_LINKS-1:0] proc_stat,
  output sncr_pkg::sncr_link_cfg_type [EXT_LINKS-1:0] ext_cfg,
  output logic [PROC_LINKS-1:0][1:0] proc_net,
  input wire logic [1:0] core_halted_flag,
  input wire logic ext_debug_req,
  output logic shared_debug_net,
  output logic [1:0] debug_request,
  input wire logic route_req,
  input wire logic [15:0] route_dest,
  output logic route_valid,
  output logic [3:0] route_dir,
  output logic route_mismatch,
  output logic [15:0] node_id,
  output logic [15:0] switch_clock_ratio,
  output logic [15:0] reference_clock_ratio
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (EXT_LINKS < 1 || EXT_LINKS > 9) begin : g_bad_ext
    $error("EXT_LINKS must be 1..9");
  end
  if (PROC_LINKS < 1 || PROC_LINKS > 8) begin : g_bad_proc
    $error("PROC_LINKS must be 1..8");
  end

  logic [31:0] dirs_low, next_dirs_low;
  logic [31:0] dirs_high, next_dirs_high;
  logic [15:0] next_node_id, next_sw_div, next_ref_div;
  logic [1:0][1:0] dbg_cfg, next_dbg_cfg;
  logic [4:0] dbg_src, next_dbg_src;
  sncr_pkg::sncr_link_cfg_type [EXT_LINKS-1:0] next_ext_cfg;
  logic [PROC_LINKS-1:0][1:0] next_proc_net;
  logic next_ack;
  logic [31:0] next_rdata;
  logic next_net;
  logic [1:0] next_dbg_req;
  logic net_event;
  logic [4:0] src_now;
  logic pick_mismatch;
  logic [3:0] pick_dir;
  logic wr, rd;

  assign wr = cfg_req.valid & cfg_req.write;
  assign rd = cfg_req.valid & ~cfg_req.write;

  // ----------------------------------------
  // routing
  // ----------------------------------------
  sncr_route_pick u_pick (
    .node_id(node_id),
    .dest(route_dest),
    .dirs_low(dirs_low),
    .dirs_high(dirs_high),
    .dir(pick_dir),
    .mismatch(pick_mismatch)
  );

  // ----------------------------------------
  // debug net
  // ----------------------------------------
  always_comb begin
    next_net = ext_debug_req;
    src_now = 5'h00;
    src_now[sncr_pkg::SRC_EXT_BIT] = ext_debug_req;
    for (int t = 0; t < sncr_pkg::TILES; t++) begin
      if (core_halted_flag[t] && dbg_cfg[t][sncr_pkg::DBG_DRIVE_EN_BIT]) begin
        next_net = 1'b1;
      end
    end
    src_now[sncr_pkg::SRC_CORE0_BIT] = core_halted_flag[0] & dbg_cfg[0][sncr_pkg::DBG_DRIVE_EN_BIT];
    src_now[sncr_pkg::SRC_CORE1_BIT] = core_halted_flag[1] & dbg_cfg[1][sncr_pkg::DBG_DRIVE_EN_BIT];
    net_event = next_net & ~shared_debug_net;
    for (int t = 0; t < sncr_pkg::TILES; t++) begin
      next_dbg_req[t] = next_net & dbg_cfg[t][sncr_pkg::DBG_REQ_EN_BIT];
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_comb begin
    next_node_id = node_id;
    next_sw_div = switch_clock_ratio;
    next_ref_div = reference_clock_ratio;
    next_dirs_low = dirs_low;
    next_dirs_high = dirs_high;
    next_dbg_cfg = dbg_cfg;
    next_dbg_src = dbg_src;
    next_ext_cfg = ext_cfg;
    next_proc_net = proc_net;
    if (wr) begin
      case (cfg_req.addr)
        sncr_pkg::ADDR_NODE_ID: next_node_id = cfg_req.wdata[15:0];
        sncr_pkg::ADDR_SW_DIV: next_sw_div = cfg_req.wdata[15:0];
        sncr_pkg::ADDR_REF_DIV: next_ref_div = cfg_req.wdata[15:0];
        sncr_pkg::ADDR_DIR_LO: next_dirs_low = cfg_req.wdata;
        sncr_pkg::ADDR_DIR_HI: next_dirs_high = cfg_req.wdata;
        sncr_pkg::ADDR_DBG_CFG0: next_dbg_cfg[0] = cfg_req.wdata[1:0];
        sncr_pkg::ADDR_DBG_CFG0 + 8'h01: next_dbg_cfg[1] = cfg_req.wdata[1:0];
        sncr_pkg::ADDR_DBG_SRC: begin
          next_dbg_src = cfg_req.wdata[4:0] & 5'h13;
        end
        default: begin
          // only direction and network bits of link words take writes
          for (int i = 0; i < EXT_LINKS; i++) begin
            if (cfg_req.addr == sncr_pkg::ADDR_EXT_BASE + 8'(i)) begin
              next_ext_cfg[i].dir = cfg_req.wdata[sncr_pkg::LNK_DIR_LSB+:4];
              next_ext_cfg[i].net = cfg_req.wdata[sncr_pkg::LNK_NET_LSB+:2];
            end
          end
          for (int i = 0; i < PROC_LINKS; i++) begin
            if (cfg_req.addr == sncr_pkg::ADDR_PROC_BASE + 8'(i)) begin
              next_proc_net[i] = cfg_req.wdata[sncr_pkg::LNK_NET_LSB+:2];
            end
          end
        end
      endcase
    end
    // a new debug event beats a software write in the same cycle
    if (net_event) begin
      next_dbg_src = src_now;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    next_ack = cfg_req.valid;
    next_rdata = cfg_rdata;
    if (rd) begin
      next_rdata = 32'h0000_0000;
      case (cfg_req.addr)
        sncr_pkg::ADDR_NODE_ID: next_rdata[15:0] = node_id;
        sncr_pkg::ADDR_SW_DIV: next_rdata[15:0] = switch_clock_ratio;
        sncr_pkg::ADDR_REF_DIV: next_rdata[15:0] = reference_clock_ratio;
        sncr_pkg::ADDR_SCAN_ID: next_rdata = SCAN_ID;
        sncr_pkg::ADDR_USER: next_rdata = {OTP_USER_CODE, METAL_ID};
        sncr_pkg::ADDR_DIR_LO: next_rdata = dirs_low;
        sncr_pkg::ADDR_DIR_HI: next_rdata = dirs_high;
        sncr_pkg::ADDR_DBG_CFG0: next_rdata[1:0] = dbg_cfg[0];
        sncr_pkg::ADDR_DBG_CFG0 + 8'h01: next_rdata[1:0] = dbg_cfg[1];
        sncr_pkg::ADDR_DBG_SRC: next_rdata[4:0] = dbg_src;
        default: begin
          for (int i = 0; i < EXT_LINKS; i++) begin
            if (cfg_req.addr == sncr_pkg::ADDR_EXT_BASE + 8'(i)) begin
              next_rdata = sncr_pkg::sncr_status_word(ext_stat[i], ext_cfg[i].dir, ext_cfg[i].net);
            end
          end
          for (int i = 0; i < PROC_LINKS; i++) begin
            if (cfg_req.addr == sncr_pkg::ADDR_PROC_BASE + 8'(i)) begin
              // no direction field on processor links
              next_rdata = sncr_pkg::sncr_status_word(proc_stat[i], 4'h0, proc_net[i]);
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      node_id <= sncr_pkg::RST_NODE_ID;
      switch_clock_ratio <= sncr_pkg::RST_SW_DIV;
      reference_clock_ratio <= sncr_pkg::RST_REF_DIV;
      dirs_low <= sncr_pkg::RST_DIRS;
      dirs_high <= sncr_pkg::RST_DIRS;
      dbg_cfg <= '0;
      dbg_src <= 5'h00;
      ext_cfg <= '0;
      proc_net <= '0;
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
      shared_debug_net <= 1'b0;
      debug_request <= 2'h0;
      route_valid <= 1'b0;
      route_dir <= 4'h0;
      route_mismatch <= 1'b0;
    end else begin
      node_id <= next_node_id;
      switch_clock_ratio <= next_sw_div;
      reference_clock_ratio <= next_ref_div;
      dirs_low <= next_dirs_low;
      dirs_high <= next_dirs_high;
      dbg_cfg <= next_dbg_cfg;
      dbg_src <= next_dbg_src;
      ext_cfg <= next_ext_cfg;
      proc_net <= next_proc_net;
      cfg_ack <= next_ack;
      cfg_rdata <= next_rdata;
      shared_debug_net <= next_net;
      debug_request <= next_dbg_req;
      route_valid <= route_req;
      route_dir <= route_req ? pick_dir : route_dir;
      route_mismatch <= route_req ? pick_mismatch : route_mismatch;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_cfg_write(logic [7:0] a);
    cfg_req.valid && cfg_req.write && cfg_req.addr == a;
  endsequence
  sequence s_cfg_read(logic [7:0] a);
    cfg_req.valid && !cfg_req.write && cfg_req.addr == a;
  endsequence

  a_ack_one_cycle: assert property (cfg_req.valid |=> cfg_ack ##0 $past(cfg_req.valid))
    else $error("config access not answered in one cycle");
  a_sw_div_write: assert property (s_cfg_write(sncr_pkg::ADDR_SW_DIV) |=>
    switch_clock_ratio == $past(cfg_req.wdata[15:0]))
    else $error("switch divider write lost");
  a_ref_div_read: assert property (s_cfg_read(sncr_pkg::ADDR_REF_DIV) |=>
    cfg_rdata == {16'h0000, reference_clock_ratio})
    else $error("reference divider read wrong");
  a_user_code_read: assert property (s_cfg_read(sncr_pkg::ADDR_USER) |=>
    cfg_rdata[31:18] == OTP_USER_CODE && cfg_rdata[17:0] == METAL_ID)
    else $error("user code read wrong");
  a_scan_id_read: assert property (s_cfg_read(sncr_pkg::ADDR_SCAN_ID) |=> cfg_rdata == SCAN_ID)
    else $error("scan identity read wrong");
  a_dir_low_write: assert property (s_cfg_write(sncr_pkg::ADDR_DIR_LO) |=>
    dirs_low == $past(cfg_req.wdata))
    else $error("low direction table write lost");
  a_route_top_dim: assert property (route_req && route_dest[15] != node_id[15] |=>
    route_valid && route_mismatch && route_dir == $past(dirs_high[31:28]))
    else $error("dimension 15 route wrong");
  a_route_match: assert property (route_req && route_dest == node_id |=> !route_mismatch)
    else $error("matching destination reported as mismatch");
  a_dbg_drive: assert property (core_halted_flag[0] && dbg_cfg[0][sncr_pkg::DBG_DRIVE_EN_BIT]
    |=> shared_debug_net)
    else $error("halted core did not drive debug net");
  a_dbg_request: assert property (shared_debug_net && $past(dbg_cfg[1][sncr_pkg::DBG_REQ_EN_BIT])
    |-> debug_request[1])
    else $error("debug request not raised");
  a_src_capture: assert property ($rose(shared_debug_net) |->
    dbg_src[sncr_pkg::SRC_EXT_BIT] == $past(ext_debug_req))
    else $error("debug source not captured");
  a_link_kind_read: assert property (s_cfg_read(sncr_pkg::ADDR_EXT_BASE) |=>
    cfg_rdata[25:16] == $past({ext_stat[0].kind, ext_stat[0].dest}))
    else $error("link status read wrong");
  a_proc_no_dir: assert property (s_cfg_read(sncr_pkg::ADDR_PROC_BASE) |=>
    cfg_rdata[15:6] == 10'h000 && cfg_rdata[31:26] == 6'h00)
    else $error("processor link reserved bits nonzero");
endmodule
`default_nettype wire

// >>> rtl/sncr_pkg.sv
package sncr_pkg;
  // ----------------------------------------
  // register offsets, as node config numbers
  // ----------------------------------------
  localparam logic [7:0] ADDR_NODE_ID = 8'h05;
  localparam logic [7:0] ADDR_SW_DIV = 8'h07;
  localparam logic [7:0] ADDR_REF_DIV = 8'h08;
  localparam logic [7:0] ADDR_SCAN_ID = 8'h09;
  localparam logic [7:0] ADDR_USER = 8'h0A;
  localparam logic [7:0] ADDR_DIR_LO = 8'h0C;
  localparam logic [7:0] ADDR_DIR_HI = 8'h0D;
  localparam logic [7:0] ADDR_DBG_CFG0 = 8'h10;
  localparam logic [7:0] ADDR_DBG_SRC = 8'h1F;
  localparam logic [7:0] ADDR_EXT_BASE = 8'h20;
  localparam logic [7:0] ADDR_PROC_BASE = 8'h40;
  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int EXT_LINKS = 9;
  localparam int PROC_LINKS = 8;
  localparam int TILES = 2;
  localparam logic [15:0] RST_NODE_ID = 16'h0000;
  localparam logic [15:0] RST_SW_DIV = 16'h0000;
  localparam logic [15:0] RST_REF_DIV = 16'h0003;
  localparam logic [31:0] RST_DIRS = 32'h0000_0000;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int USER_OTP_LSB = 18;
  localparam int DBG_REQ_EN_BIT = 1;
  localparam int DBG_DRIVE_EN_BIT = 0;
  localparam int SRC_EXT_BIT = 4;
  localparam int SRC_CORE1_BIT = 1;
  localparam int SRC_CORE0_BIT = 0;
  localparam int LNK_KIND_LSB = 24;
  localparam int LNK_DEST_LSB = 16;
  localparam int LNK_DIR_LSB = 8;
  localparam int LNK_NET_LSB = 4;
  localparam int LNK_JUNK_BIT = 2;
  localparam int LNK_DBUSY_BIT = 1;
  localparam int LNK_SBUSY_BIT = 0;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sncr_cfg_req_type;
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] dest;
    logic junk;
    logic dst_busy;
    logic src_busy;
  } sncr_link_stat_type;
  typedef struct packed {
    logic [3:0] dir;
    logic [1:0] net;
  } sncr_link_cfg_type;

  // one status word layout for both link kinds; reserved bits stay zero
  function automatic logic [31:0] sncr_status_word(sncr_link_stat_type s, logic [3:0] dir, logic [1:0] net);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[LNK_KIND_LSB+:2] = s.kind;
    w[LNK_DEST_LSB+:8] = s.dest;
    w[LNK_DIR_LSB+:4] = dir;
    w[LNK_NET_LSB+:2] = net;
    w[LNK_JUNK_BIT] = s.junk;
    w[LNK_DBUSY_BIT] = s.dst_busy;
    w[LNK_SBUSY_BIT] = s.src_busy;
    return w;
  endfunction
endpackage

// >>> rtl/sncr_route_pick.sv
`timescale 1ns/1ps
`default_nettype none
module sncr_route_pick (
  input wire logic [15:0] node_id,
  input wire logic [15:0] dest,
  input wire logic [31:0] dirs_low,
  input wire logic [31:0] dirs_high,
  output logic [3:0] dir,
  output logic mismatch
);
  logic [15:0] diff;
  logic [63:0] table_all;
  logic [3:0] dim;

  // ----------------------------------------
  // most significant differing bit
  // ----------------------------------------
  always_comb begin
    diff = node_id ^ dest;
    table_all = {dirs_high, dirs_low};
    dim = 4'h0;
    mismatch = 1'b0;
    for (int k = 0; k < 16; k++) begin
      if (diff[k]) begin
        dim = 4'(k);
        mismatch = 1'b1;
      end
    end
    // dimension k lives at bits 4k+3..4k of the joined tables
    dir = table_all[{dim, 2'b00}+:4];
  end
endmodule
`default_nettype wire

// >>> tb/sncr_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module sncr_fabric_model #(
  parameter int EXT_LINKS = sncr_pkg::EXT_LINKS,
  parameter int PROC_LINKS = sncr_pkg::PROC_LINKS
) (
  input wire logic traffic,
  input wire logic [1:0] halt,
  input wire logic pin,
  output sncr_pkg::sncr_link_stat_type [EXT_LINKS-1:0] ext_stat,
  output sncr_pkg::sncr_link_stat_type [PROC_LINKS-1:0] proc_stat,
  output logic [1:0] core_halted_flag,
  output logic ext_debug_req
);
  // -------------------------------------
  // link state
  // -------------------------------------
  // kinds cycle through all four codes; dest only shown while a route is held
  always_comb begin
    for (int i = 0; i < EXT_LINKS; i++) begin
      ext_stat[i].kind = 2'(i);
      ext_stat[i].dest = traffic ? 8'h10 + 8'(i) : 8'h00;
      ext_stat[i].junk = traffic & i[0];
      ext_stat[i].dst_busy = traffic;
      ext_stat[i].src_busy = traffic;
    end
    for (int i = 0; i < PROC_LINKS; i++) begin
      proc_stat[i].kind = 2'(i + 1);
      proc_stat[i].dest = traffic ? 8'h80 + 8'(i) : 8'h00;
      proc_stat[i].junk = traffic & i[0];
      proc_stat[i].dst_busy = traffic;
      proc_stat[i].src_busy = traffic;
    end
    core_halted_flag = halt;
    ext_debug_req = pin;
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
  localparam int NE = sncr_pkg::EXT_LINKS;
  localparam int NP = sncr_pkg::PROC_LINKS;
  localparam logic [31:0] SID = 32'hA5C3_0F01; // arbitrary value
  localparam logic [13:0] OTP = 14'h2A5C; // arbitrary value
  localparam logic [17:0] MID = 18'h12345; // arbitrary value
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  sncr_pkg::sncr_cfg_req_type cfg_req = '0;
  logic cfg_ack;
  logic [31:0] cfg_rdata;
  sncr_pkg::sncr_link_stat_type [NE-1:0] ext_stat;
  sncr_pkg::sncr_link_stat_type [NP-1:0] proc_stat;
  sncr_pkg::sncr_link_cfg_type [NE-1:0] ext_cfg;
  logic [NP-1:0][1:0] proc_net;
  logic [1:0] core_halted_flag;
  logic ext_debug_req;
  logic shared_debug_net;
  logic [1:0] debug_request;
  logic route_req = 1'b0;
  logic [15:0] route_dest = 16'h0000;
  logic route_valid;
  logic [3:0] route_dir;
  logic route_mismatch;
  logic [15:0] node_id;
  logic [15:0] switch_clock_ratio;
  logic [15:0] reference_clock_ratio;
  logic traffic = 1'b0;
  logic [1:0] halt = 2'b00;
  logic pin = 1'b0;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  always #10 sys_clk = ~sys_clk;

  sncr_node_regs #(.SCAN_ID(SID), .OTP_USER_CODE(OTP), .METAL_ID(MID)) sncr_node_regs_i (
    .sys_clk(sys_clk), .rst(rst), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .ext_stat(ext_stat), .proc_stat(proc_stat), .ext_cfg(ext_cfg), .proc_net(proc_net),
    .core_halted_flag(core_halted_flag), .ext_debug_req(ext_debug_req),
    .shared_debug_net(shared_debug_net), .debug_request(debug_request), .route_req(route_req),
    .route_dest(route_dest), .route_valid(route_valid), .route_dir(route_dir),
    .route_mismatch(route_mismatch), .node_id(node_id), .switch_clock_ratio(switch_clock_ratio),
    .reference_clock_ratio(reference_clock_ratio)
  );

  sncr_fabric_model sncr_fabric_model_i (
    .traffic(traffic), .halt(halt), .pin(pin), .ext_stat(ext_stat), .proc_stat(proc_stat),
    .core_halted_flag(core_halted_flag), .ext_debug_req(ext_debug_req)
  );

  // ------------------------------------
  // access tasks
  // ------------------------------------
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    cfg_req <= {1'b1, w, a, d};
    @(posedge sys_clk);
    cfg_req.valid <= 1'b0;
    @(negedge sys_clk);
    `CHK(cfg_ack, 1'b1)
    q = cfg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask

  task automatic route(input logic [15:0] d, input logic [3:0] e, input logic m);
    @(posedge sys_clk);
    route_req <= 1'b1;
    route_dest <= d;
    @(posedge sys_clk);
    route_req <= 1'b0;
    @(negedge sys_clk);
    `CHK(route_valid, 1'b1)
    `CHK(route_dir, e)
    `CHK(route_mismatch, m)
  endtask

  // fabric changes land one edge before the design samples them
  task automatic fab(input logic t, input logic [1:0] h, input logic p);
    @(posedge sys_clk);
    traffic <= t;
    halt <= h;
    pin <= p;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  function automatic logic [31:0] lw(input int i, input logic p, input logic t, input logic [5:0] c);
    logic [7:0] base;
    base = p ? 8'h80 : 8'h10;
    return {6'h00, p ? 2'(i + 1) : 2'(i), t ? base + 8'(i) : 8'h00, 4'h0, p ? 4'h0 : c[5:2],
            2'h0, c[1:0], 1'b0, t & i[0], t, t};
  endfunction

  task automatic final_report;
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  // ------------------------------------
  // main sequence
  // ------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK(reference_clock_ratio, 16'h0003)
    rd(sncr_pkg::ADDR_NODE_ID, 32'h0000_0000);
    rd(sncr_pkg::ADDR_SW_DIV, 32'h0000_0000);
    rd(sncr_pkg::ADDR_REF_DIV, 32'h0000_0003);
    rd(sncr_pkg::ADDR_DIR_LO, 32'h0000_0000);
    rd(sncr_pkg::ADDR_DIR_HI, 32'h0000_0000);
    rd(sncr_pkg::ADDR_DBG_CFG0, 32'h0000_0000);
    rd(8'h11, 32'h0000_0000);
    wr(sncr_pkg::ADDR_SW_DIV, 32'hFFFF_FFFF);
    rd(sncr_pkg::ADDR_SW_DIV, 32'h0000_FFFF);
    `CHK(switch_clock_ratio, 16'hFFFF)
    wr(sncr_pkg::ADDR_REF_DIV, 32'hABCD_1234);
    rd(sncr_pkg::ADDR_REF_DIV, 32'h0000_1234);
    wr(sncr_pkg::ADDR_NODE_ID, 32'hFFFF_5A3C);
    rd(sncr_pkg::ADDR_NODE_ID, 32'h0000_5A3C);
    `CHK(node_id, 16'h5A3C)
    wr(sncr_pkg::ADDR_SCAN_ID, 32'h0000_0000);
    rd(sncr_pkg::ADDR_SCAN_ID, SID);
    wr(sncr_pkg::ADDR_USER, 32'h0000_0000);
    rd(sncr_pkg::ADDR_USER, {OTP, MID});
    wr(sncr_pkg::ADDR_DIR_LO, 32'h7654_3210);
    rd(sncr_pkg::ADDR_DIR_LO, 32'h7654_3210);
    wr(sncr_pkg::ADDR_DIR_HI, 32'hFEDC_BA98);
    rd(sncr_pkg::ADDR_DIR_HI, 32'hFEDC_BA98);
    // every lower bit flipped too, so only the top mismatch may decide
    for (int k = 0; k < 16; k++) begin
      route(16'h5A3C ^ (16'hFFFF >> (15 - k)), 4'(k), 1'b1);
    end
    route(16'h5A3C, 4'h0, 1'b0);
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0000_0000);
    rd(8'h48, 32'h0000_0000);
    for (int ps = 0; ps < 2; ps++) begin
      fab(ps == 0, 2'b00, 1'b0);
      for (int i = 0; i < NE; i++) begin
        rd(8'(sncr_pkg::ADDR_EXT_BASE + i), lw(i, 1'b0, ps == 0, ps ? 6'h3F : 6'h00));
        wr(8'(sncr_pkg::ADDR_EXT_BASE + i), 32'hFFFF_FFFF);
      end
      for (int i = 0; i < NP; i++) begin
        rd(8'(sncr_pkg::ADDR_PROC_BASE + i), lw(i, 1'b1, ps == 0, ps ? 6'h3F : 6'h00));
        wr(8'(sncr_pkg::ADDR_PROC_BASE + i), 32'hFFFF_FFFF);
      end
    end
    for (int i = 0; i < NE; i++) `CHK(ext_cfg[i], 6'h3F)
    for (int i = 0; i < NP; i++) `CHK(proc_net[i], 2'h3)
    wr(sncr_pkg::ADDR_DBG_CFG0, 32'hFFFF_FFFD);
    rd(sncr_pkg::ADDR_DBG_CFG0, 32'h0000_0001);
    wr(8'h11, 32'h0000_0002);
    fab(1'b0, 2'b01, 1'b0);
    `CHK(shared_debug_net, 1'b1)
    `CHK(debug_request, 2'b10)
    rd(sncr_pkg::ADDR_DBG_SRC, 32'h0000_0001);
    fab(1'b0, 2'b10, 1'b0);
    `CHK(shared_debug_net, 1'b0)
    `CHK(debug_request, 2'b00)
    fab(1'b0, 2'b10, 1'b1);
    `CHK(debug_request, 2'b10)
    rd(sncr_pkg::ADDR_DBG_SRC, 32'h0000_0010);
    fab(1'b0, 2'b00, 1'b0);
    wr(sncr_pkg::ADDR_DBG_SRC, 32'hFFFF_FFFF);
    rd(sncr_pkg::ADDR_DBG_SRC, 32'h0000_0013);
    final_report();
  end
endmodule
`default_nettype wire
